// File: src/port_regs_defines.vh
/*
 * Constants for the per-port control and status register set of a quad-port
 * power-sourcing manager: register-select codes, field positions, reset values,
 * function codes and status encodings.
 * Assumes it is included by its bare name from the design files.
 */
// Overview of operation
// - Each port has function, port-control and two status registers, selects 0010 to 0101.
// - Discovery-fault-disable set makes the port ignore its discovery resistance limits.
// - DC-disconnect-disable set suspends DC disconnect detection on that port.
// - Function field resets to zero; code zero powers down and resets port functions.
// - Code 0001 starts first discovery step, code 0010 the second.
// - Code 0011 takes one port voltage sample.
// - Code 0100 runs legacy detection, code 0101 runs classification.
// - Code 0110 ramps up and powers the port; 0111 samples continuously.
// - Code 1000 ramps power down; 1001 and 1010 select low and high AC disconnect.
// - Code 1011 samples port current; code 1100 samples die temperature.
// - Port-disable bit disables the port; clear means normal; resets to zero.
// - Host writes one to converter start; device starts conversion and clears the bit.
// - Writing one to converter abort aborts the conversion in progress.
// - Discovery-status bit reads one after a failed discovery; resets to zero.
// - Function-done sets on completion and clears when a new function code is written; a completion in the same cycle as the write keeps it set.
// - Port-class field reports class 0 to 4 as 000 to 100; resets to 000.
// - Fault field: none, supply out of range, overheat, overload, disconnect.
// - Watchdog flag reads one while the port watchdog timer is active.
// - Converter-status flag reads one while a conversion is in progress.
// - Function-state field reports disabled, searching, power, fault, test, other fault.
`ifndef PORT_REGS_DEFINES_VH
`define PORT_REGS_DEFINES_VH

// Register-select codes
`define SEL_FUNC_CTRL      4'h2
`define SEL_PORT_CTRL      4'h3
`define SEL_DET_STATUS     4'h4
`define SEL_ACT_STATUS     4'h5

// Function-control fields
`define FC_DISC_FLT_DIS    5
`define FC_DC_DISC_DIS     4
`define FC_FUNC_MSB        3
`define FC_FUNC_LSB        0
`define FC_WRITE_MASK      8'h3f
`define FC_RESET           8'h00

// Port-control fields
`define PC_PORT_DIS        4
`define PC_CONV_START      3
`define PC_CONV_ABORT      2
`define PC_WRITE_MASK      8'h1c
`define PC_RESET           8'h00

// Function codes
`define FN_DISABLE         4'h0
`define FN_DISCOVERY1      4'h1
`define FN_DISCOVERY2      4'h2
`define FN_V_SAMPLE        4'h3
`define FN_LEGACY          4'h4
`define FN_CLASSIFY        4'h5
`define FN_RAMP_UP         4'h6
`define FN_CONT_SAMPLE     4'h7
`define FN_RAMP_DOWN       4'h8
`define FN_AC_LOW          4'h9
`define FN_AC_HIGH         4'ha
`define FN_I_SAMPLE        4'hb
`define FN_T_SAMPLE        4'hc
`define FN_LAST_VALID      4'hc

// Fault codes
`define FLT_NONE           3'h0
`define FLT_SUPPLY_RANGE   3'h1
`define FLT_OVERHEAT       3'h2
`define FLT_OVERLOAD       3'h3
`define FLT_DISCONNECT     3'h4

// Function-state codes
`define ST_DISABLED        3'h0
`define ST_SEARCHING       3'h1
`define ST_POWER           3'h2
`define ST_FAULT           3'h3
`define ST_TEST            3'h4
`define ST_OTHER_FAULT     3'h5

// Class limit
`define CLASS_MAX          3'h4

`endif

// File: src/port_reg_slice.v
/*
 * One port's register slice: function control, port control and the live
 * status that the core reports. Holds the command handshake to the core.
 * Assumes the core drives its status inputs synchronously to i_mclk.
 */
`timescale 1ns/1ns
`default_nettype none
`include "port_regs_defines.vh"

module port_reg_slice (
    input  wire       i_mclk,          // Core clock
    input  wire       i_srst,          // Synchronous reset, active high
    input  wire       i_ce,            // Clock enable
    input  wire       i_wr,            // Write strobe for this port
    input  wire [3:0] i_sel,           // Register select
    input  wire [7:0] i_wdata,         // Write data
    input  wire       i_func_done,     // Core: commanded function complete (pulse)
    input  wire       i_disc_fail,     // Core: discovery attempt failed (pulse)
    input  wire       i_disc_ok,       // Core: discovery attempt passed (pulse)
    input  wire [2:0] i_class,         // Core: detected class
    input  wire       i_class_vld,     // Core: class result valid (pulse)
    input  wire [2:0] i_fault,         // Core: fault code
    input  wire       i_wdog_act,      // Core: watchdog active
    input  wire       i_conv_busy,     // Core: conversion in progress
    input  wire [2:0] i_state,         // Core: function state
    output reg  [7:0] o_func_ctrl,     // Function-control register
    output reg  [7:0] o_port_ctrl,     // Port-control register
    output reg  [7:0] o_det_status,    // Detection/fault status register
    output reg  [7:0] o_act_status,    // Activity/state status register
    output reg        o_func_go,       // Pulse: new function code to run
    output reg        o_conv_go,       // Pulse: start conversion
    output reg        o_conv_stop      // Pulse: abort conversion
);

    wire fc_wr = i_wr && (i_sel == `SEL_FUNC_CTRL);
    wire pc_wr = i_wr && (i_sel == `SEL_PORT_CTRL);
    wire spare = i_wdata[`FC_FUNC_MSB:`FC_FUNC_LSB] > `FN_LAST_VALID;

    reg       done_reg;
    reg       disc_reg;
    reg [2:0] class_reg;
    reg [2:0] class_in;

    // Class above 4 cannot be reported, so clamp it
    always @* begin
        class_in = (i_class > `CLASS_MAX) ? `CLASS_MAX : i_class;
    end

    // Control registers and command pulses
    always @(posedge i_mclk) begin
        if (i_srst) begin
            o_func_ctrl <= `FC_RESET;
            o_port_ctrl <= `PC_RESET;
            o_func_go   <= 1'b0;
            o_conv_go   <= 1'b0;
            o_conv_stop <= 1'b0;
        end else if (i_ce) begin
            o_func_go   <= 1'b0;
            o_conv_go   <= 1'b0;
            o_conv_stop <= 1'b0;
            // Spare codes keep the running function; the disable bits still take
            if (fc_wr) begin
                if (spare) begin
                    o_func_ctrl[`FC_DISC_FLT_DIS:`FC_DC_DISC_DIS] <=
                        i_wdata[`FC_DISC_FLT_DIS:`FC_DC_DISC_DIS];
                end else begin
                    o_func_ctrl <= i_wdata & `FC_WRITE_MASK;
                    o_func_go   <= 1'b1;
                end
            end
            // Start bit is held one cycle while the core takes it, then cleared
            if (pc_wr) begin
                o_port_ctrl <= i_wdata & `PC_WRITE_MASK;
                o_conv_go   <= i_wdata[`PC_CONV_START];
                o_conv_stop <= i_wdata[`PC_CONV_ABORT];
            end else if (o_port_ctrl[`PC_CONV_START]) begin
                o_port_ctrl[`PC_CONV_START] <= 1'b0;
            end
        end
    end

    // Sticky status: a completion in the write cycle wins over the clear
    always @(posedge i_mclk) begin
        if (i_srst) begin
            done_reg  <= 1'b0;
            disc_reg  <= 1'b0;
            class_reg <= 3'h0;
        end else if (i_ce) begin
            if (i_func_done)
                done_reg <= 1'b1;
            else if (fc_wr && !spare)
                done_reg <= 1'b0;
            if (i_disc_fail)
                disc_reg <= 1'b1;
            else if (i_disc_ok)
                disc_reg <= 1'b0;
            if (i_class_vld)
                class_reg <= class_in;
        end
    end

    // Status images, unused bits forced to zero
    always @(posedge i_mclk) begin
        if (i_srst) begin
            o_det_status <= 8'h00;
            o_act_status <= 8'h00;
        end else if (i_ce) begin
            o_det_status <= {disc_reg, done_reg, class_reg, i_fault};
            o_act_status <= {3'h0, i_wdog_act, i_conv_busy, i_state};
        end
    end

endmodule
`default_nettype wire

// File: src/poe_port_control_status_regs.v
/*
 * Per-port control and status registers for four power-sourcing ports.
 * Register access is a select code plus a port number, as the management
 * interface decodes it; control decodes drive per-port function strobes.
 * Assumes the serial management decoder and port core share i_mclk.
 */
`timescale 1ns/1ns
`default_nettype none
`include "port_regs_defines.vh"

module poe_port_control_status_regs #(
    parameter NPORT = 4                                // Number of ports
) (
    input  wire                i_mclk,          // 25 MHz core clock
    input  wire                i_srst,          // Synchronous reset, active high
    input  wire                i_ce,            // Clock enable, freezes state when low
    input  wire                i_wr,            // Register write strobe
    input  wire                i_rd,            // Register read strobe
    input  wire [3:0]          i_sel,           // Register select code
    input  wire [1:0]          i_port,          // Port number
    input  wire [7:0]          i_wdata,         // Write data
    input  wire [NPORT-1:0]    i_func_done,     // Per port: function complete pulse
    input  wire [NPORT-1:0]    i_disc_fail,     // Per port: discovery failed pulse
    input  wire [NPORT-1:0]    i_disc_ok,       // Per port: discovery passed pulse
    input  wire [3*NPORT-1:0]  i_class,         // Per port: class result
    input  wire [NPORT-1:0]    i_class_vld,     // Per port: class valid pulse
    input  wire [3*NPORT-1:0]  i_fault,         // Per port: fault code
    input  wire [NPORT-1:0]    i_wdog_act,      // Per port: watchdog active
    input  wire [NPORT-1:0]    i_conv_busy,     // Per port: conversion running
    input  wire [3*NPORT-1:0]  i_state,         // Per port: function state
    output reg  [7:0]          o_rdata,         // Read data
    output reg                 o_rvalid,        // Read data valid pulse
    output reg  [NPORT-1:0]    o_disc_lim_off,  // Ignore discovery resistance limits
    output reg  [NPORT-1:0]    o_dc_disc_off,   // Suspend DC disconnect detection
    output reg  [NPORT-1:0]    o_port_off,      // Port disabled
    output reg  [NPORT-1:0]    o_power_down,    // Pulse: power down, reset functions
    output reg  [NPORT-1:0]    o_disc1_go,      // Pulse: first discovery step
    output reg  [NPORT-1:0]    o_disc2_go,      // Pulse: second discovery step
    output reg  [NPORT-1:0]    o_vsample_go,    // Pulse: single voltage sample
    output reg  [NPORT-1:0]    o_legacy_go,     // Pulse: legacy detection
    output reg  [NPORT-1:0]    o_classify_go,   // Pulse: classification
    output reg  [NPORT-1:0]    o_ramp_up_go,    // Pulse: ramp up and power
    output reg  [NPORT-1:0]    o_cont_sample,   // Level: continuous sampling selected
    output reg  [NPORT-1:0]    o_ramp_down_go,  // Pulse: ramp power down
    output reg  [NPORT-1:0]    o_ac_low_sel,    // Level: low AC disconnect selected
    output reg  [NPORT-1:0]    o_ac_high_sel,   // Level: high AC disconnect selected
    output reg  [NPORT-1:0]    o_isample_go,    // Pulse: port current sample
    output reg  [NPORT-1:0]    o_tsample_go,    // Pulse: die temperature sample
    output reg  [NPORT-1:0]    o_conv_go,       // Pulse: start conversion
    output reg  [NPORT-1:0]    o_conv_stop      // Pulse: abort conversion
);

    wire [8*NPORT-1:0] fc_w;
    wire [8*NPORT-1:0] pc_w;
    wire [8*NPORT-1:0] ds_w;
    wire [8*NPORT-1:0] as_w;
    wire [NPORT-1:0]   fgo_w;
    wire [NPORT-1:0]   cgo_w;
    wire [NPORT-1:0]   cstop_w;

    genvar g;
    // One slice per port; the port number steers the write strobe
    generate
        for (g = 0; g < NPORT; g = g + 1) begin : port
            port_reg_slice u_slice (
                .i_mclk       (i_mclk),
                .i_srst       (i_srst),
                .i_ce         (i_ce),
                .i_wr         (i_wr && (i_port == g)),
                .i_sel        (i_sel),
                .i_wdata      (i_wdata),
                .i_func_done  (i_func_done[g]),
                .i_disc_fail  (i_disc_fail[g]),
                .i_disc_ok    (i_disc_ok[g]),
                .i_class      (i_class[3*g+2:3*g]),
                .i_class_vld  (i_class_vld[g]),
                .i_fault      (i_fault[3*g+2:3*g]),
                .i_wdog_act   (i_wdog_act[g]),
                .i_conv_busy  (i_conv_busy[g]),
                .i_state      (i_state[3*g+2:3*g]),
                .o_func_ctrl  (fc_w[8*g+7:8*g]),
                .o_port_ctrl  (pc_w[8*g+7:8*g]),
                .o_det_status (ds_w[8*g+7:8*g]),
                .o_act_status (as_w[8*g+7:8*g]),
                .o_func_go    (fgo_w[g]),
                .o_conv_go    (cgo_w[g]),
                .o_conv_stop  (cstop_w[g])
            );
        end
    endgenerate

    // Read mux over the four per-port registers; other selects read zero
    reg [7:0] rd_mux;
    always @* begin
        case (i_sel)
            `SEL_FUNC_CTRL:  rd_mux = fc_w[8*i_port +: 8];
            `SEL_PORT_CTRL:  rd_mux = pc_w[8*i_port +: 8];
            `SEL_DET_STATUS: rd_mux = ds_w[8*i_port +: 8];
            `SEL_ACT_STATUS: rd_mux = as_w[8*i_port +: 8];
            default:         rd_mux = 8'h00;
        endcase
    end

    always @(posedge i_mclk) begin
        if (i_srst) begin
            o_rdata  <= 8'h00;
            o_rvalid <= 1'b0;
        end else if (i_ce) begin
            o_rvalid <= i_rd;
            if (i_rd)
                o_rdata <= rd_mux;
        end
    end

    // Decode each port's function code into strobes and levels, one cycle after the write
    integer p;
    always @(posedge i_mclk) begin
        if (i_srst) begin
            o_disc_lim_off <= {NPORT{1'b0}};
            o_dc_disc_off  <= {NPORT{1'b0}};
            o_port_off     <= {NPORT{1'b0}};
            o_power_down   <= {NPORT{1'b0}};
            o_disc1_go     <= {NPORT{1'b0}};
            o_disc2_go     <= {NPORT{1'b0}};
            o_vsample_go   <= {NPORT{1'b0}};
            o_legacy_go    <= {NPORT{1'b0}};
            o_classify_go  <= {NPORT{1'b0}};
            o_ramp_up_go   <= {NPORT{1'b0}};
            o_cont_sample  <= {NPORT{1'b0}};
            o_ramp_down_go <= {NPORT{1'b0}};
            o_ac_low_sel   <= {NPORT{1'b0}};
            o_ac_high_sel  <= {NPORT{1'b0}};
            o_isample_go   <= {NPORT{1'b0}};
            o_tsample_go   <= {NPORT{1'b0}};
            o_conv_go      <= {NPORT{1'b0}};
            o_conv_stop    <= {NPORT{1'b0}};
        end else if (i_ce) begin
            for (p = 0; p < NPORT; p = p + 1) begin
                o_disc_lim_off[p] <= fc_w[8*p+`FC_DISC_FLT_DIS];
                o_dc_disc_off[p]  <= fc_w[8*p+`FC_DC_DISC_DIS];
                o_port_off[p]     <= pc_w[8*p+`PC_PORT_DIS];
                o_conv_go[p]      <= cgo_w[p];
                o_conv_stop[p]    <= cstop_w[p];
                // Levels follow the stored code so a spare write keeps them
                o_cont_sample[p]  <= (fc_w[8*p +: 4] == `FN_CONT_SAMPLE);
                o_ac_low_sel[p]   <= (fc_w[8*p +: 4] == `FN_AC_LOW);
                o_ac_high_sel[p]  <= (fc_w[8*p +: 4] == `FN_AC_HIGH);
                o_power_down[p]   <= fgo_w[p] && (fc_w[8*p +: 4] == `FN_DISABLE);
                o_disc1_go[p]     <= fgo_w[p] && (fc_w[8*p +: 4] == `FN_DISCOVERY1);
                o_disc2_go[p]     <= fgo_w[p] && (fc_w[8*p +: 4] == `FN_DISCOVERY2);
                o_vsample_go[p]   <= fgo_w[p] && (fc_w[8*p +: 4] == `FN_V_SAMPLE);
                o_legacy_go[p]    <= fgo_w[p] && (fc_w[8*p +: 4] == `FN_LEGACY);
                o_classify_go[p]  <= fgo_w[p] && (fc_w[8*p +: 4] == `FN_CLASSIFY);
                o_ramp_up_go[p]   <= fgo_w[p] && (fc_w[8*p +: 4] == `FN_RAMP_UP);
                o_ramp_down_go[p] <= fgo_w[p] && (fc_w[8*p +: 4] == `FN_RAMP_DOWN);
                o_isample_go[p]   <= fgo_w[p] && (fc_w[8*p +: 4] == `FN_I_SAMPLE);
                o_tsample_go[p]   <= fgo_w[p] && (fc_w[8*p +: 4] == `FN_T_SAMPLE);
            end
        end
    end

endmodule
`default_nettype wire

// File: test/poe_regs_checker_properties.sv
/* Checker for the per-port register set, watching port 0 strobes.
   Assumes one clock, i_ce high during checked writes. */
`timescale 1ns/1ns
`default_nettype none
`include "port_regs_defines.vh"
module poe_regs_checker #(parameter NPORT = 4) (
    input wire logic             i_mclk, i_srst, i_ce, i_wr, i_rd, // Clock, reset, strobes
    input wire logic [3:0]       i_sel,                            // Register select
    input wire logic [1:0]       i_port,                           // Port number
    input wire logic [7:0]       i_wdata,                          // Write data
    input wire logic             o_rvalid,                         // Read valid
    input wire logic [NPORT-1:0] o_power_down, o_disc1_go, o_ramp_up_go, o_tsample_go,
    input wire logic [NPORT-1:0] o_conv_go, o_conv_stop, o_port_off // Port 0 is watched
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    // Accepted writes to port 0
    wire wf = i_ce && i_wr && i_port == 2'h0 && i_sel == `SEL_FUNC_CTRL;
    wire wp = i_ce && i_wr && i_port == 2'h0 && i_sel == `SEL_PORT_CTRL;
    wire [3:0] fn = i_wdata[3:0];
    property p_rvalid; i_ce && i_rd |=> o_rvalid; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    property p_off; wf && fn == `FN_DISABLE |-> ##2 o_power_down[0]; endproperty
    a_off: assert property (p_off) else $error("no power down");
    property p_disc1; wf && fn == `FN_DISCOVERY1 |-> ##2 o_disc1_go[0]; endproperty
    a_disc1: assert property (p_disc1) else $error("no discovery start");
    property p_ramp; wf && fn == `FN_RAMP_UP |-> ##2 o_ramp_up_go[0]; endproperty
    a_ramp: assert property (p_ramp) else $error("no ramp up");
    property p_tsamp; wf && fn == `FN_T_SAMPLE |-> ##2 o_tsample_go[0]; endproperty
    a_tsamp: assert property (p_tsamp) else $error("no temperature sample");
    property p_spare;
        wf && fn > `FN_LAST_VALID |-> ##2 !(o_power_down[0] || o_disc1_go[0] ||
            o_ramp_up_go[0] || o_tsample_go[0]);
    endproperty
    a_spare: assert property (p_spare) else $error("spare code acted");
    property p_start; wp && i_wdata[3] |-> ##2 o_conv_go[0] ##1 !o_conv_go[0]; endproperty
    a_start: assert property (p_start) else $error("start pulse wrong");
    property p_abort; wp && i_wdata[2] |-> ##2 o_conv_stop[0]; endproperty
    a_abort: assert property (p_abort) else $error("no abort pulse");
    property p_pdis; wp |-> ##2 o_port_off[0] == $past(i_wdata[4], 2); endproperty
    a_pdis: assert property (p_pdis) else $error("port disable wrong");
    c_start: cover property (o_conv_go[0]);
    c_read: cover property (o_rvalid);
    c_off: cover property (o_power_down[0]);
endmodule
bind poe_port_control_status_regs poe_regs_checker #(.NPORT(NPORT)) u_chk (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_ce(i_ce), .i_wr(i_wr), .i_rd(i_rd),
    .i_sel(i_sel), .i_port(i_port), .i_wdata(i_wdata), .o_rvalid(o_rvalid),
    .o_power_down(o_power_down), .o_disc1_go(o_disc1_go), .o_ramp_up_go(o_ramp_up_go),
    .o_tsample_go(o_tsample_go), .o_conv_go(o_conv_go), .o_conv_stop(o_conv_stop),
    .o_port_off(o_port_off));
`default_nettype wire

// File: test/port_core_model.sv
/* Behavioural port core: answers function strobes with done, class and
   discovery results, and tracks conversion and function state.
   Assumes one-cycle strobes on i_mclk. */
`timescale 1ns/1ns
`default_nettype none
`include "port_regs_defines.vh"
module port_core_model #(parameter NPORT = 4, parameter DONE_DLY = 4) (
    input wire logic             i_mclk, i_srst,                  // Clock, reset
    input wire logic [NPORT-1:0] i_any_go, i_disc1_go, i_search_go, // Function strobes
    input wire logic [NPORT-1:0] i_ramp_up_go, i_power_down, i_conv_go, i_conv_stop,
    output var logic [NPORT-1:0] o_func_done, o_disc_fail, o_class_vld, o_conv_busy,
    output wire logic [NPORT-1:0] o_disc_ok,                      // Never passes discovery
    output wire logic [3*NPORT-1:0] o_class,                      // Always class 3
    output var logic [3*NPORT-1:0] o_state                        // Function state
);
    integer p;
    logic [3:0]       cnt [0:NPORT-1];
    logic [NPORT-1:0] fail_pend;
    assign o_disc_ok = '0;
    assign o_class = {NPORT{3'h3}};
    // Slow answer: each function finishes DONE_DLY cycles after its strobe
    always @(posedge i_mclk) begin
        o_func_done <= '0;
        o_disc_fail <= '0;
        o_class_vld <= '0;
        if (i_srst) begin
            o_conv_busy <= '0;
            o_state <= '0;
            fail_pend <= '0;
            for (p = 0; p < NPORT; p = p + 1) cnt[p] <= 4'h0;
        end else for (p = 0; p < NPORT; p = p + 1) begin
            if (i_conv_stop[p]) o_conv_busy[p] <= 1'b0;
            else if (i_conv_go[p]) o_conv_busy[p] <= 1'b1;
            if (i_power_down[p]) o_state[3*p+:3] <= `ST_DISABLED;
            else if (i_ramp_up_go[p]) o_state[3*p+:3] <= `ST_POWER;
            else if (i_search_go[p]) o_state[3*p+:3] <= `ST_SEARCHING;
            if (i_power_down[p]) cnt[p] <= 4'h0;
            else if (i_any_go[p]) begin
                cnt[p] <= DONE_DLY;
                fail_pend[p] <= i_disc1_go[p];
            end else if (cnt[p] != 4'h0) begin
                cnt[p] <= cnt[p] - 4'h1;
                if (cnt[p] == 4'h1) begin
                    o_func_done[p] <= 1'b1;
                    o_class_vld[p] <= 1'b1;
                    o_disc_fail[p] <= fail_pend[p];
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: test/poe_port_control_status_regs_tb_top.sv
/* Self-checking bench for the per-port register set with a core model.
   Assumes a 25 MHz clock; i_ce is dropped for one write only. */
`timescale 1ns/1ns
`default_nettype none
`include "port_regs_defines.vh"
module poe_port_control_status_regs_tb_top;
    logic clk = 0, srst = 1, wr = 0, rd = 0, ce = 1;
    logic [3:0] sel = 0, wdog = 0;
    logic [1:0] port = 0;
    logic [7:0] wdata = 0, got;
    logic [11:0] fault = 0;
    wire [7:0] rdata;
    wire rvalid;
    wire [3:0] lo, dco, po, pd, d1, d2, vs, lg, cl, ru, cs, rdn, acl, ach, is, ts, cg, cst;
    wire [3:0] done, dfail, dok, cvld, busy;
    wire [11:0] cls, st;
    integer error_cnt = 0, n_tests = 0, i;
    always #20 clk = ~clk;
    // Design under test; clock enable is dropped once to check the freeze
    poe_port_control_status_regs dut (.i_mclk(clk), .i_srst(srst), .i_ce(ce), .i_wr(wr),
        .i_rd(rd), .i_sel(sel), .i_port(port), .i_wdata(wdata), .i_func_done(done),
        .i_disc_fail(dfail), .i_disc_ok(dok), .i_class(cls), .i_class_vld(cvld),
        .i_fault(fault), .i_wdog_act(wdog), .i_conv_busy(busy), .i_state(st),
        .o_rdata(rdata), .o_rvalid(rvalid), .o_disc_lim_off(lo), .o_dc_disc_off(dco),
        .o_port_off(po), .o_power_down(pd), .o_disc1_go(d1), .o_disc2_go(d2),
        .o_vsample_go(vs), .o_legacy_go(lg), .o_classify_go(cl), .o_ramp_up_go(ru),
        .o_cont_sample(cs), .o_ramp_down_go(rdn), .o_ac_low_sel(acl), .o_ac_high_sel(ach),
        .o_isample_go(is), .o_tsample_go(ts), .o_conv_go(cg), .o_conv_stop(cst));
    // Core model answers every strobe that starts a timed function
    port_core_model core (.i_mclk(clk), .i_srst(srst), .i_any_go(d1|d2|vs|lg|cl|ru|rdn|is|ts),
        .i_disc1_go(d1), .i_search_go(d1|d2|lg|cl), .i_ramp_up_go(ru), .i_power_down(pd),
        .i_conv_go(cg), .i_conv_stop(cst), .o_func_done(done), .o_disc_fail(dfail),
        .o_class_vld(cvld), .o_conv_busy(busy), .o_disc_ok(dok), .o_class(cls), .o_state(st));
    function automatic [15:0] pv(input integer p);
        pv = {3'h0, ts[p], is[p], ach[p], acl[p], rdn[p], cs[p], ru[p], cl[p], lg[p],
              vs[p], d2[p], d1[p], pd[p]};
    endfunction
    task automatic check(input [15:0] seen, input [15:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wt(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input [1:0] p, input [3:0] s, input [7:0] d);
        port = p; sel = s; wdata = d; wr = 1;
        wt(1);
        wr = 0;
    endtask
    task automatic rreg(input [1:0] p, input [3:0] s);
        port = p; sel = s; rd = 1;
        wt(1);
        rd = 0;
        check(rvalid, 1);
        got = rdata;
        wt(1);
    endtask
    // Every register of every port reads zero after reset
    task automatic t_reset;
        for (i = 8; i < 24; i = i + 1) begin
            rreg(i[3:2], i[1:0] + 4'h2);
            check(got, 0);
        end
        rreg(0, 4'h9);
        check(got, 0);
        $display("reset test done");
    endtask
    // Each function code gives exactly its own strobe; spare codes give no strobe but still set the disable bits
    task automatic t_funcs;
        for (i = 0; i <= 12; i = i + 1) begin
            wreg(0, `SEL_FUNC_CTRL, i[7:0]);
            wt(1);
            check(pv(0), 16'h1 << i);
            rreg(0, `SEL_FUNC_CTRL);
            check(got, i[7:0]);
        end
        wreg(0, `SEL_FUNC_CTRL, 8'hfd);
        wt(1);
        check(pv(0), 0);
        rreg(0, `SEL_FUNC_CTRL);
        check(got, 8'h3c);
        wreg(0, `SEL_FUNC_CTRL, 8'hf0);
        wt(2);
        check({lo[0], dco[0]}, 2'b11);
        rreg(0, `SEL_FUNC_CTRL);
        check(got, 8'h30);
        wreg(0, `SEL_FUNC_CTRL, 8'h00);
        wt(2);
        check({lo[0], dco[0]}, 2'b00);
        $display("function test done");
    endtask
    // Start clears itself, abort and disable stay stored
    task automatic t_portctl;
        wreg(0, `SEL_PORT_CTRL, 8'hfc);
        wt(1);
        check({cg[0], cst[0], po[0]}, 3'b111);
        wt(1);
        check(cg[0], 0);
        rreg(0, `SEL_PORT_CTRL);
        check(got, 8'h14);
        wreg(0, `SEL_PORT_CTRL, 8'h00);
        wt(2);
        check(po[0], 0);
        // A write while the clock enable is low must not land
        ce = 0;
        wreg(0, `SEL_PORT_CTRL, 8'h10);
        ce = 1;
        wt(1);
        check(po[0], 0);
        $display("port control test done");
    endtask
    // Status images of port 3 follow the core model
    task automatic t_status;
        fault[11:9] = `FLT_OVERLOAD;
        wdog[3] = 1;
        wreg(3, `SEL_FUNC_CTRL, `FN_CLASSIFY);
        wt(12);
        rreg(3, `SEL_DET_STATUS);
        check(got, 8'h5b);
        wreg(3, `SEL_DET_STATUS, 8'hff);
        wt(1);
        wreg(3, `SEL_FUNC_CTRL, `FN_DISCOVERY1);
        wt(12);
        rreg(3, `SEL_DET_STATUS);
        check(got, 8'hdb);
        wreg(3, `SEL_FUNC_CTRL, `FN_DISABLE);
        wt(4);
        rreg(3, `SEL_DET_STATUS);
        check(got & 8'h40, 0);
        rreg(3, `SEL_ACT_STATUS);
        check(got, 8'h10);
        wreg(3, `SEL_PORT_CTRL, 8'h08);
        wt(6);
        rreg(3, `SEL_ACT_STATUS);
        check(got, 8'h18);
        wreg(3, `SEL_PORT_CTRL, 8'h04);
        wt(6);
        rreg(3, `SEL_ACT_STATUS);
        check(got, 8'h10);
        wreg(3, `SEL_FUNC_CTRL, `FN_RAMP_UP);
        wt(6);
        rreg(3, `SEL_ACT_STATUS);
        check(got, 8'h12);
        for (i = 0; i <= 4; i = i + 1) begin
            fault[11:9] = i[2:0];
            wt(4);
            rreg(3, `SEL_DET_STATUS);
            check(got[2:0], i[2:0]);
        end
        $display("status test done");
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence after two cycles of reset
    initial begin
        wt(2);
        srst = 0;
        t_reset;
        t_funcs;
        t_portctl;
        t_status;
        conclude;
    end
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #100000;
        error_cnt = error_cnt + 1;
        conclude;
    end
endmodule
`default_nettype wire
